// ### verilog/m2p_chan_consts.vh
// constants of the m2p double-buffer channel: offsets, fields, states
// assumes a 32-bit apb register window per channel
`ifndef M2P_CHAN_CONSTS_VH
`define M2P_CHAN_CONSTS_VH
// ===========================================================
// register byte offsets
`define OFF_CONTROL 8'h00
`define OFF_IRQ_STATUS 8'h04
`define OFF_STATE_FLAGS 8'h0c
`define OFF_BYTES_LEFT 8'h14
`define OFF_BUF0_LIMIT 8'h20
`define OFF_BUF0_START 8'h24
`define OFF_BUF0_PTR 8'h28
`define OFF_BUF1_LIMIT 8'h30
`define OFF_BUF1_START 8'h34
`define OFF_BUF1_PTR 8'h38
// ===========================================================
// control fields
`define CTL_HALT_IRQ_EN 0
`define CTL_ENABLE 3
`define CTL_ERR_IRQ_EN 4
`define CTL_NEWBUF_IRQ_EN 5
`define CTL_ABORT 6
`define CTL_IGNORE_ERR 7
`define CTL_ADDR_HOLD 8
// ===========================================================
// irq status fields
`define IRQ_HALT 0
`define IRQ_NEWBUF 1
`define IRQ_ERR 2
// ===========================================================
// state flags fields
`define ST_STALL 3
`define ST_STATE_LO 4
`define ST_STATE_HI 5
`define ST_NEWBUF 6
`define ST_ERROR 7
`define ST_FREEBUF 8
`define ST_BYTES_LO 9
`define ST_BYTES_HI 11
// ===========================================================
// channel states and reset values
`define S_IDLE 2'h0
`define S_STALL 2'h1
`define S_ON 2'h2
`define S_NEXT 2'h3
`define RST_WORD 32'h0000_0000
`define RST_COUNT 16'h0000
`endif

// ### verilog/byte_packer.v
// byte packer: counts bytes staged between peripheral and bus words
// assumes one byte per pulse and a flush when a word is handed on
`timescale 1ns/1ps
module byte_packer #(
	parameter CW = 3
) (
	input wire pclk,
	input wire presetn,
	input wire clear,
	input wire byte_in,
	input wire word_out,
	output reg [CW-1:0] held_q
);
	// ===========================================================
	// occupancy, saturates at four bytes per word
	reg [CW-1:0] held_d;
	always @* begin
		held_d = held_q;
		if (clear || word_out) begin
			held_d = {CW{1'b0}};
		end else if (byte_in && held_q != 3'h4) begin
			held_d = held_q + 3'h1;
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_q <= 3'h0;
		end else begin
			held_q <= held_d;
		end
	end
endmodule // byte_packer

// ### verilog/m2p_dma_channel.v
// m2p channel: double buffer tracking, status and apb registers
// assumes apb slave, peripheral byte strobes synchronous to pclk
//
// Summary of operation
// - stall flag set entering stall from on at buffer end
// - no stall flag entering stall from idle
// - leave stall on start write or disable
// - next to on sets new-buffer-needed
// - new-buffer-needed raises irq unless masked
// - error flag shows last buffer outcome
// - status shows bytes held in packer
// - state encoded idle stall on next
// - start0 write sets, start1 clears free indicator
// - idle-buffer write waits for current buffer end
// - active buffer from state and indicator
// - load 16-bit byte count entering on
// - count down one per byte moved
// - zero count ends buffer, terminal count out
// - peripheral early finish leaves count nonzero
// - early finish with error sets error flag
// - enable goes to stall, start goes on
// - start write copies address into pointer
// - pointer keeps post-incremented address at end
// - disable or start write clears newbuf irq
// - halt irq on on-to-stall only if enabled
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "m2p_chan_consts.vh"
module m2p_dma_channel #(
	parameter CW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire tx_mode,
	input wire byte_moved,
	input wire word_moved,
	input wire early_finish,
	input wire early_error,
	output reg tx_terminal_count,
	output reg rx_terminal_count,
	output wire [31:0] bus_addr,
	output wire xfer_active,
	output wire irq
);
	// ===========================================================
	// apb decode
	reg [31:0] prdata_q;
	reg [31:0] control_q;
	reg [2:0] irq_q;
	reg [1:0] state_q;
	reg newbuf_q, error_q, free_q, stall_vis_q;
	reg [CW-1:0] lim0_q, lim1_q, left_q;
	reg [31:0] start0_q, start1_q, ptr0_q, ptr1_q;
	reg pend_q;
	wire [2:0] held;
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire wr_ctl = wr && paddr == `OFF_CONTROL;
	wire wr_irq = wr && paddr == `OFF_IRQ_STATUS;
	wire wr_s0 = wr && paddr == `OFF_BUF0_START;
	wire wr_s1 = wr && paddr == `OFF_BUF1_START;
	wire enable = control_q[`CTL_ENABLE];
	wire mapped = paddr == `OFF_CONTROL || paddr == `OFF_IRQ_STATUS ||
		paddr == `OFF_STATE_FLAGS || paddr == `OFF_BYTES_LEFT ||
		paddr == `OFF_BUF0_LIMIT || paddr == `OFF_BUF0_START ||
		paddr == `OFF_BUF0_PTR || paddr == `OFF_BUF1_LIMIT ||
		paddr == `OFF_BUF1_START || paddr == `OFF_BUF1_PTR;
	// read data registered in setup, ready always high
	// capturing in setup keeps prdata a flop without costing a wait state
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign prdata = prdata_q;
	// ===========================================================
	// active buffer and buffer end
	// indicator names the free pair; active is derived from state
	wire act1 = (state_q == `S_ON) ? !free_q : free_q;
	wire moving = state_q == `S_ON || state_q == `S_NEXT;
	wire step = moving && byte_moved;
	wire tc_hit = step && left_q == {{(CW-1){1'b0}}, 1'b1};
	wire early = moving && early_finish;
	wire bad = early && early_error && !control_q[`CTL_IGNORE_ERR];
	wire buf_end = tc_hit || early;
	wire [31:0] act_ptr = act1 ? ptr1_q : ptr0_q;
	wire [31:0] inc = control_q[`CTL_ADDR_HOLD] ? 32'h0 : 32'h1;
	assign bus_addr = act_ptr;
	assign xfer_active = moving;
	// ===========================================================
	// state machine
	reg [1:0] state_d;
	reg load_d;
	always @* begin
		state_d = state_q;
		load_d = 1'b0;
		if (!enable) begin
			state_d = `S_IDLE;
		end else begin
			case (state_q)
			`S_IDLE: begin
				state_d = `S_STALL;
			end
			`S_STALL: begin
				if (wr_s0 || wr_s1) begin
					state_d = `S_ON;
					load_d = 1'b1;
				end
			end
			`S_ON: begin
				if (buf_end) begin
					state_d = `S_STALL;
				end else if (wr_s0 || wr_s1) begin
					state_d = `S_NEXT;
				end
			end
			`S_NEXT: begin
				// abort on an error stops the channel, no halt irq for it
				if (buf_end) begin
					if (bad && control_q[`CTL_ABORT]) begin
						state_d = `S_STALL;
					end else begin
						state_d = `S_ON;
						load_d = 1'b1;
					end
				end
			end
			default: state_d = `S_IDLE;
			endcase
		end
	end
	// the buffer loaded is the one the indicator does not mark free:
	// indicator low names buffer 0 free, so buffer 1 is loaded
	// from stall the written start register picks the buffer
	wire ld1 = (state_q == `S_STALL) ? wr_s1 : !free_q;
	wire to_stall_from_on = enable && state_q == `S_ON && buf_end;
	wire abort_stall = state_d == `S_STALL && state_q == `S_NEXT;
	// ===========================================================
	// registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_q <= `RST_WORD;
			irq_q <= 3'h0;
			state_q <= `S_IDLE;
			newbuf_q <= 1'b0;
			error_q <= 1'b0;
			free_q <= 1'b0;
			stall_vis_q <= 1'b0;
			lim0_q <= `RST_COUNT;
			lim1_q <= `RST_COUNT;
			left_q <= `RST_COUNT;
			start0_q <= `RST_WORD;
			start1_q <= `RST_WORD;
			ptr0_q <= `RST_WORD;
			ptr1_q <= `RST_WORD;
			pend_q <= 1'b0;
			prdata_q <= `RST_WORD;
			tx_terminal_count <= 1'b0;
			rx_terminal_count <= 1'b0;
		end else begin
			state_q <= state_d;
			if (wr_ctl) begin
				control_q <= pwdata;
			end
			if (wr && paddr == `OFF_BUF0_LIMIT) begin
				lim0_q <= pwdata[CW-1:0];
			end
			if (wr && paddr == `OFF_BUF1_LIMIT) begin
				lim1_q <= pwdata[CW-1:0];
			end
			if (wr_s0) begin
				start0_q <= pwdata;
				free_q <= 1'b1;
			end
			if (wr_s1) begin
				start1_q <= pwdata;
				free_q <= 1'b0;
			end
			if (!enable) begin
				pend_q <= 1'b0;
			end else if (wr_s0 || wr_s1) begin
				pend_q <= 1'b1;
			end else if (load_d) begin
				pend_q <= 1'b0;
			end
			// stall entered from idle stays hidden
			if (state_d != `S_STALL) begin
				stall_vis_q <= 1'b0;
			end else if (to_stall_from_on) begin
				stall_vis_q <= 1'b1;
			end
			// pointer copy on start write in stall while enabled
			if (enable && wr_s0 && state_q == `S_STALL) begin
				ptr0_q <= pwdata;
			end else if (enable && wr_s1 && state_q == `S_STALL) begin
				ptr1_q <= pwdata;
			end else begin
				// the last byte of a buffer still steps its pointer, even
				// in the cycle that loads the other pointer for the switch
				if (step && !act1) begin
					ptr0_q <= ptr0_q + inc;
				end
				if (step && act1) begin
					ptr1_q <= ptr1_q + inc;
				end
				// later assignment wins; a load never hits the active one
				if (load_d && !ld1) begin
					ptr0_q <= start0_q;
				end
				if (load_d && ld1) begin
					ptr1_q <= start1_q;
				end
			end
			if (load_d) begin
				if (ld1) begin
					left_q <= (state_q == `S_STALL && wr_s1) ?
						lim1_q : lim1_q;
				end else begin
					left_q <= lim0_q;
				end
			end else if (step && left_q != `RST_COUNT) begin
				left_q <= left_q - {{(CW-1){1'b0}}, 1'b1};
			end
			tx_terminal_count <= tc_hit && tx_mode;
			rx_terminal_count <= tc_hit && !tx_mode;
			if (bad) begin
				error_q <= 1'b1;
			end else if (buf_end) begin
				error_q <= 1'b0;
			end
			if (state_q == `S_NEXT && state_d == `S_ON) begin
				newbuf_q <= 1'b1;
			end else if (state_d != `S_ON) begin
				newbuf_q <= 1'b0;
			end
			// set beats clear on every sticky bit
			if (state_q == `S_NEXT && state_d == `S_ON &&
				control_q[`CTL_NEWBUF_IRQ_EN]) begin
				irq_q[`IRQ_NEWBUF] <= 1'b1;
			end else if (!enable || wr_s0 || wr_s1) begin
				irq_q[`IRQ_NEWBUF] <= 1'b0;
			end
			if (to_stall_from_on && !abort_stall &&
				control_q[`CTL_HALT_IRQ_EN]) begin
				irq_q[`IRQ_HALT] <= 1'b1;
			end else if (!enable || wr_s0 || wr_s1) begin
				irq_q[`IRQ_HALT] <= 1'b0;
			end
			if (bad) begin
				irq_q[`IRQ_ERR] <= 1'b1;
			end else if (wr_irq) begin
				irq_q[`IRQ_ERR] <= 1'b0;
			end
			if (psel && !penable) begin
				case (paddr)
				`OFF_CONTROL: prdata_q <= control_q;
				`OFF_IRQ_STATUS: prdata_q <= {29'h0, irq_q};
				`OFF_STATE_FLAGS: prdata_q <= {20'h0,
					held, free_q, error_q, newbuf_q,
					state_q, stall_vis_q, 3'h0};
				`OFF_BYTES_LEFT: prdata_q <= {16'h0, left_q};
				`OFF_BUF0_LIMIT: prdata_q <= {16'h0, lim0_q};
				`OFF_BUF0_START: prdata_q <= start0_q;
				`OFF_BUF0_PTR: prdata_q <= ptr0_q;
				`OFF_BUF1_LIMIT: prdata_q <= {16'h0, lim1_q};
				`OFF_BUF1_START: prdata_q <= start1_q;
				`OFF_BUF1_PTR: prdata_q <= ptr1_q;
				default: prdata_q <= 32'h0;
				endcase
			end
		end
	end
	assign irq = |(irq_q & {control_q[`CTL_ERR_IRQ_EN], 2'h3});
	// ===========================================================
	// packer occupancy for debug
	byte_packer #(.CW(3)) u_packer (
		.pclk(pclk),
		.presetn(presetn),
		.clear(!enable),
		.byte_in(step),
		.word_out(word_moved),
		.held_q(held)
	);
endmodule // m2p_dma_channel

// ### tb/m2p_chan_asserts.sv
// port-level checker for the m2p double-buffer channel
// assumes it is bound to m2p_dma_channel, one clock domain
`timescale 1ns/1ps
`include "m2p_chan_consts.vh"
module m2p_chan_asserts (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire tx_mode,
	input wire byte_moved,
	input wire tx_terminal_count,
	input wire rx_terminal_count,
	input wire [31:0] bus_addr,
	input wire xfer_active
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
wire acc = psel && penable;
wire tc = tx_terminal_count || rx_terminal_count;
// ===========================================================
// sequences
sequence byte_s;
	byte_moved && xfer_active && !(acc && pwrite);
endsequence
sequence state_rd_s;
	acc && !pwrite && paddr == `OFF_STATE_FLAGS;
endsequence
// ===========================================================
// properties
unmapped_err_a: assert property (acc |-> pslverr == !(paddr inside
	{8'h00, 8'h04, 8'h0c, 8'h14, 8'h20, 8'h24, 8'h28, 8'h30, 8'h34,
	8'h38})) else $error("slave error decode wrong");
tc_pulse_a: assert property (tc |=> !tc)
	else $error("terminal count longer than one cycle");
tc_cause_a: assert property (tc |->
	$past(byte_moved) && $past(xfer_active))
	else $error("terminal count without a moved byte");
tc_mode_a: assert property (tc |->
	tx_terminal_count == $past(tx_mode))
	else $error("terminal count on wrong direction line");
addr_step_a: assert property (byte_s ##1 !tc |->
	bus_addr == $past(bus_addr) + 32'h0000_0001)
	else $error("address did not step by one byte");
disable_stop_a: assert property (acc && pwrite &&
	paddr == `OFF_CONTROL && !pwdata[`CTL_ENABLE] |=> !xfer_active)
	else $error("transfer still active after disable");
state_read_a: assert property (state_rd_s |->
	prdata[`ST_STATE_HI] == $past(xfer_active))
	else $error("state field disagrees with transfer activity");
stall_read_a: assert property (state_rd_s |->
	!prdata[`ST_STALL] || prdata[5:4] == `S_STALL)
	else $error("stall flag outside stall state");
endmodule // m2p_chan_asserts
bind m2p_dma_channel m2p_chan_asserts chk_u (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
	.tx_mode(tx_mode), .byte_moved(byte_moved),
	.tx_terminal_count(tx_terminal_count),
	.rx_terminal_count(rx_terminal_count), .bus_addr(bus_addr),
	.xfer_active(xfer_active));

// ### tb/fifo_port_model.sv
// peripheral fifo port model: byte strobes, packer flush, early finish
// assumes one bench process calls its tasks, drives after rising edges
`timescale 1ns/1ps
module fifo_port_model (
	input wire pclk,
	output reg byte_moved,
	output reg word_moved,
	output reg early_finish,
	output reg early_error
);
initial begin
	byte_moved = 1'b0;
	word_moved = 1'b0;
	early_finish = 1'b0;
	early_error = 1'b1;
end
// back to back bytes; flush is optional so the packer count shows
task send(input integer n, input reg flush);
	integer i;
	begin
		for (i = 0; i < n; i = i + 1) begin
			@(posedge pclk);
			byte_moved <= 1'b1;
		end
		@(posedge pclk);
		byte_moved <= 1'b0;
		word_moved <= flush;
		@(posedge pclk);
		word_moved <= 1'b0;
	end
endtask
// error qualifier goes to the inverse outside the finish cycle
task finish(input reg err);
	begin
		@(posedge pclk);
		early_finish <= 1'b1;
		early_error <= err;
		@(posedge pclk);
		early_finish <= 1'b0;
		early_error <= ~err;
	end
endtask
endmodule // fifo_port_model

// ### tb/m2p_dma_channel_buffer_status_tb.sv
// bench for the m2p channel: apb register tasks plus fifo port model
// assumes zero wait-state apb slave and a 200 mhz pclk
`timescale 1ns/1ps
`include "m2p_chan_consts.vh"
module m2p_dma_channel_buffer_status_tb;
localparam [79:0] map = 80'h00040c14202428303438;
localparam [31:0] all_m = 32'hffff_ffff;
reg pclk = 1'b0;
reg presetn = 1'b0;
reg psel = 1'b0;
reg penable = 1'b0;
reg pwrite = 1'b0;
reg [7:0] paddr = 8'h00;
reg [31:0] pwdata = 32'h0000_0000;
reg tx_mode = 1'b1;
wire [31:0] prdata;
wire [31:0] bus_addr;
wire pready, pslverr, xfer_active, irq;
wire byte_moved, word_moved, early_finish, early_error;
wire tx_terminal_count, rx_terminal_count;
integer n_mismatch = 0;
integer compares = 0;
integer n_tx = 0;
integer n_rx = 0;
integer i;
reg [31:0] rv;
always #2.5 pclk = ~pclk;
always @(posedge pclk) begin
	if (tx_terminal_count === 1'b1) n_tx <= n_tx + 1;
	if (rx_terminal_count === 1'b1) n_rx <= n_rx + 1;
end
m2p_dma_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tx_mode(tx_mode), .byte_moved(byte_moved), .word_moved(word_moved),
	.early_finish(early_finish), .early_error(early_error),
	.tx_terminal_count(tx_terminal_count),
	.rx_terminal_count(rx_terminal_count), .bus_addr(bus_addr),
	.xfer_active(xfer_active), .irq(irq));
fifo_port_model pm_u (.pclk(pclk), .byte_moved(byte_moved),
	.word_moved(word_moved), .early_finish(early_finish),
	.early_error(early_error));
// ===========================================================
// tasks
task chk(input [31:0] seen, input [31:0] exp);
	begin
		compares = compares + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	end
endtask
task apb(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rv = {prdata[31:1], prdata[0]};
		if (w === 1'b0 && a == 8'h08) chk({31'h0, pslverr}, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	end
endtask
task rc(input [7:0] a, input [31:0] m, input [31:0] e);
	begin
		apb(1'b0, a, 32'h0000_0000);
		chk(rv & m, e);
	end
endtask
task report_and_stop;
	begin
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
endtask
initial begin
	#50000;
	n_mismatch = n_mismatch + 1;
	report_and_stop;
end
// ===========================================================
// sequence of tests
initial begin
	repeat (6) @(posedge pclk);
	presetn <= 1'b1;
	for (i = 0; i < 10; i = i + 1) rc(map[79-8*i -: 8], all_m, `RST_WORD);
	rc(8'h08, all_m, 32'h0000_0000);
	apb(1'b1, 8'h0c, all_m);
	rc(8'h0c, all_m, 32'h0000_0000);
	apb(1'b1, 8'h20, 32'h0000_0003);
	rc(8'h20, all_m, 32'h0000_0003);
	apb(1'b1, 8'h00, 32'h0000_0039);
	rc(8'h0c, 32'h1f8, 32'h0000_0010);
	apb(1'b1, 8'h24, 32'h0000_0100);
	rc(8'h0c, 32'h1f8, 32'h0000_0120);
	rc(8'h14, all_m, 32'h0000_0003);
	rc(8'h28, all_m, 32'h0000_0100);
	apb(1'b1, 8'h30, 32'h0001_0002);
	apb(1'b1, 8'h34, 32'h0000_0200);
	rc(8'h0c, 32'h1f8, 32'h0000_0030);
	chk(bus_addr, 32'h0000_0100);
	pm_u.send(3, 1'b1);
	rc(8'h0c, 32'h1f8, 32'h0000_0060);
	chk(n_tx, 32'h1);
	rc(8'h04, 32'h7, 32'h2);
	chk({31'h0, irq}, 32'h1);
	rc(8'h14, all_m, 32'h0000_0002);
	rc(8'h28, all_m, 32'h0000_0103);
	chk(bus_addr, 32'h0000_0200);
	pm_u.send(1, 1'b0);
	rc(8'h0c, 32'he00, 32'h0000_0200);
	pm_u.finish(1'b1);
	rc(8'h0c, 32'h1b8, 32'h0000_0098);
	rc(8'h14, all_m, 32'h0000_0001);
	rc(8'h38, all_m, 32'h0000_0201);
	rc(8'h04, 32'h7, 32'h7);
	apb(1'b1, 8'h20, 32'h0000_0002);
	apb(1'b1, 8'h24, 32'h0000_0300);
	rc(8'h0c, 32'h138, 32'h0000_0120);
	rc(8'h04, 32'h7, 32'h4);
	apb(1'b1, 8'h04, 32'h0000_0000);
	rc(8'h04, 32'h7, 32'h0);
	chk({31'h0, irq}, 32'h0);
	tx_mode <= 1'b0;
	pm_u.send(2, 1'b1);
	rc(8'h0c, 32'h1b8, 32'h0000_0118);
	rc(8'h14, all_m, 32'h0000_0000);
	rc(8'h28, all_m, 32'h0000_0302);
	chk(n_rx, 32'h1);
	chk(n_tx, 32'h1);
	apb(1'b1, 8'h00, 32'h0000_0000);
	rc(8'h0c, 32'h38, 32'h0000_0000);
	rc(8'h04, 32'h3, 32'h0);
	report_and_stop;
end
endmodule // m2p_dma_channel_buffer_status_tb
